// ===== logic/csbu_pkg.sv
`default_nettype none
package csbu_pkg;
    // Bus geometry and register offsets.
    localparam int unsigned CSBU_ADDR_W = 5;
    localparam logic [4:0] CSBU_CTRL_OFF = 5'h00;
    localparam logic [4:0] CSBU_OPND_OFF = 5'h04;
    localparam logic [4:0] CSBU_PC_OFF = 5'h08;
    localparam logic [4:0] CSBU_STATUS_REGISTER_OFF = 5'h0c;
    localparam logic [4:0] CSBU_RESULT_OFF = 5'h10;
    // Command word fields.
    localparam int unsigned CSBU_OP_LSB = 0;
    localparam int unsigned CSBU_SEL_LSB = 5;
    localparam int unsigned CSBU_K_LSB = 8;
    localparam int unsigned CSBU_TWO_WORD_BIT = 16;
    // Operand word fields.
    localparam int unsigned CSBU_RD_LSB = 0;
    localparam int unsigned CSBU_IMM_LSB = 8;
    localparam int unsigned CSBU_IO_LSB = 16;
    // Result word fields.
    localparam int unsigned CSBU_RES_TAKEN_BIT = 4;
    localparam int unsigned CSBU_RES_BUSY_BIT = 8;
    localparam int unsigned CSBU_RES_BAD_BIT = 9;
    // Status register bit positions.
    localparam int unsigned CSBU_FLAG_C = 0;
    localparam int unsigned CSBU_FLAG_Z = 1;
    localparam int unsigned CSBU_FLAG_N = 2;
    localparam int unsigned CSBU_FLAG_V = 3;
    localparam int unsigned CSBU_FLAG_S = 4;
    localparam int unsigned CSBU_FLAG_H = 5;
    localparam int unsigned CSBU_FLAG_T = 6;
    // Reset values.
    localparam logic [15:0] CSBU_PC_RST = 16'h0000;
    localparam logic [7:0] CSBU_STATUS_REGISTER_RST = 8'h00;
    // Program counter steps and cycle counts.
    localparam logic [15:0] CSBU_STEP_NEXT = 16'h0001;
    localparam logic [15:0] CSBU_STEP_SKIP1 = 16'h0002;
    localparam logic [15:0] CSBU_STEP_SKIP2 = 16'h0003;
    localparam logic [1:0] CSBU_CYC_ONE = 2'h1;
    localparam logic [1:0] CSBU_CYC_TWO = 2'h2;
    localparam logic [1:0] CSBU_CYC_THREE = 2'h3;
    // Bus responses.
    localparam logic [1:0] CSBU_RESP_OKAY = 2'h0;
    localparam logic [1:0] CSBU_RESP_SLVERR = 2'h2;
    // Operations, in command-field order.
    typedef enum logic [4:0] {
        compare_immediate_op,
        skip_reg_bit_clear_op,
        skip_reg_bit_set_op,
        skip_io_bit_clear_op,
        skip_io_bit_set_op,
        branch_status_bit_set_op,
        branch_status_bit_clear_op,
        branch_carry_set_op,
        branch_carry_clear_op,
        branch_same_or_higher_op,
        branch_lower_op,
        branch_signed_ge_op,
        branch_signed_lt_op,
        branch_half_carry_set_op,
        branch_half_carry_clear_op,
        branch_transfer_bit_set_op,
        branch_transfer_bit_clear_op,
        branch_overflow_set_op
    } csbu_op_type;
endpackage
`default_nettype wire

// ===== logic/csbu_top.sv
// Behaviour
// (RULE1) Compare-immediate sets Z N V C H from reg minus K in one clock.
// (RULE2) Register-bit-clear skip steps PC by 2 or 3 on a 0 bit, flags kept.
// (RULE3) Register-bit-set skip steps PC by 2 or 3 on a 1 bit, flags kept.
// (RULE4) I/O-bit-clear skip steps PC by 2 or 3 on a 0 bit, flags kept.
// (RULE5) I/O-bit-set skip steps PC by 2 or 3 on a 1 bit, flags kept.
// (RULE6) Status-bit-set branch goes to PC+k+1 on a 1 bit, flags kept.
// (RULE7) Status-bit-clear branch goes to PC+k+1 only on a 0 bit.
// (RULE8) Carry-clear and same-or-higher take C=0, carry-set and lower C=1.
// (RULE9) Signed greater-or-equal branches when N xor V is 0.
// (RULE10) Signed less-than branches when N xor V is 1.
// (RULE11) Half-carry set branches on H=1 and half-carry clear on H=0.
// (RULE12) Transfer-bit set branches on T=1 and transfer-bit clear on T=0.
// (RULE13) Overflow-set branches on V=1 and alters no flag.
// (RULE14) A branch takes 1 or 2 clocks, a skip 1 to 3 by skipped length.
// (RULE15) The offset k is sign-extended and added to the incremented PC.
`timescale 1ns/10ps
`default_nettype none
module csbu_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [csbu_pkg::CSBU_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [csbu_pkg::CSBU_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import csbu_pkg::*;

    // Byte-lane merge of a write into an existing word.
    function automatic logic [31:0] csbu_merge(input logic [31:0] old_w,
            input logic [31:0] new_w, input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Branch or skip condition of one operation.
    function automatic logic csbu_take(input csbu_op_type op,
            input logic [2:0] sel, input logic [7:0] rd,
            input logic [7:0] io, input logic [7:0] sr);
        logic t;
        t = 1'b0;
        case (op)
            skip_reg_bit_clear_op: t = !rd[sel]; // see RULE2
            skip_reg_bit_set_op: t = rd[sel]; // see RULE3
            skip_io_bit_clear_op: t = !io[sel]; // see RULE4
            skip_io_bit_set_op: t = io[sel]; // see RULE5
            branch_status_bit_set_op: t = sr[sel]; // see RULE6
            branch_status_bit_clear_op: t = !sr[sel]; // see RULE7
            branch_carry_set_op, branch_lower_op: begin
                t = sr[CSBU_FLAG_C]; // see RULE8
            end
            branch_carry_clear_op, branch_same_or_higher_op: begin
                t = !sr[CSBU_FLAG_C]; // see RULE8
            end
            branch_signed_ge_op: begin
                t = !(sr[CSBU_FLAG_N] ^ sr[CSBU_FLAG_V]); // see RULE9
            end
            branch_signed_lt_op: begin
                t = sr[CSBU_FLAG_N] ^ sr[CSBU_FLAG_V]; // see RULE10
            end
            branch_half_carry_set_op: t = sr[CSBU_FLAG_H]; // see RULE11
            branch_half_carry_clear_op: t = !sr[CSBU_FLAG_H]; // see RULE11
            branch_transfer_bit_set_op: t = sr[CSBU_FLAG_T]; // see RULE12
            branch_transfer_bit_clear_op: t = !sr[CSBU_FLAG_T]; // see RULE12
            branch_overflow_set_op: t = sr[CSBU_FLAG_V]; // see RULE13
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg, wdata_reg;
    logic [3:0] wstrb_reg;
    logic [4:0] awaddr_reg;
    logic [15:0] pc_reg, pc_next;
    logic [7:0] status_register_reg, status_register_next, cmp_status_register;
    logic [23:0] opnd_reg, opnd_next;
    logic [1:0] busy_cnt_reg, busy_cnt_next;
    logic [1:0] res_cyc_reg, res_cyc_next;
    logic res_taken_reg, res_taken_next, bad_reg, bad_next;

    // Both halves of a write are held; it is acted on once, then answered.
    wire do_write = !awready_reg && !wready_reg && !bvalid_reg;
    wire hit_ctrl = do_write && (awaddr_reg == CSBU_CTRL_OFF);
    wire hit_opnd = do_write && (awaddr_reg == CSBU_OPND_OFF);
    wire hit_pc = do_write && (awaddr_reg == CSBU_PC_OFF);
    wire hit_status_register = do_write && (awaddr_reg == CSBU_STATUS_REGISTER_OFF);
    wire hit_res = do_write && (awaddr_reg == CSBU_RESULT_OFF);
    wire hit_any = hit_ctrl || hit_opnd || hit_pc || hit_status_register || hit_res;

    // Command fields of the word being written to the command register.
    wire [4:0] op_raw = wdata_reg[CSBU_OP_LSB +: 5];
    wire csbu_op_type op = csbu_op_type'(op_raw);
    wire [2:0] sel = wdata_reg[CSBU_SEL_LSB +: 3];
    wire [6:0] k_ofs = wdata_reg[CSBU_K_LSB +: 7];
    wire two_word = wdata_reg[CSBU_TWO_WORD_BIT];
    wire op_ok = op_raw <= 5'(branch_overflow_set_op);
    wire busy = busy_cnt_reg != 2'h0;
    wire exec_fire = hit_ctrl && op_ok && !busy;
    wire ctrl_err = hit_ctrl && !exec_fire;

    // Operands as software last left them.
    wire [7:0] rd_val = opnd_reg[CSBU_RD_LSB +: 8];
    wire [7:0] imm_val = opnd_reg[CSBU_IMM_LSB +: 8];
    wire [7:0] io_val = opnd_reg[CSBU_IO_LSB +: 8];

    // Operation class and condition.
    wire is_cmp = op == compare_immediate_op;
    wire is_skip = (op >= skip_reg_bit_clear_op) && (op <= skip_io_bit_set_op);
    wire take = csbu_take(op, sel, rd_val, io_val, status_register_reg);

    // Offset is signed in words and added after the increment.
    wire [15:0] k_sext = {{9{k_ofs[6]}}, k_ofs}; // see RULE15
    wire [15:0] pc_inc = pc_reg + CSBU_STEP_NEXT;
    wire [15:0] br_target = pc_inc + k_sext; // see RULE15
    wire [15:0] skip_step = two_word ? CSBU_STEP_SKIP2 : CSBU_STEP_SKIP1;
    wire [15:0] skip_target = pc_reg + skip_step; // see RULE2

    // Target and clocks spent; a compare never moves beyond the next word.
    wire [15:0] pc_target = (is_cmp || !take) ? pc_inc :
        (is_skip ? skip_target : br_target);
    wire [1:0] skip_cyc = two_word ? CSBU_CYC_THREE : CSBU_CYC_TWO;
    wire [1:0] cyc_count = (is_cmp || !take) ? CSBU_CYC_ONE :
        (is_skip ? skip_cyc : CSBU_CYC_TWO); // see RULE14

    // Subtraction for the compare; the difference is never stored.
    wire [7:0] cmp_diff = rd_val - imm_val; // see RULE1
    wire cmp_h = (!rd_val[3] && imm_val[3]) || (imm_val[3] && cmp_diff[3]) ||
        (cmp_diff[3] && !rd_val[3]);
    wire cmp_c = (!rd_val[7] && imm_val[7]) || (imm_val[7] && cmp_diff[7]) ||
        (cmp_diff[7] && !rd_val[7]);
    wire cmp_v = (rd_val[7] && !imm_val[7] && !cmp_diff[7]) ||
        (!rd_val[7] && imm_val[7] && cmp_diff[7]);
    wire cmp_n = cmp_diff[7];
    wire cmp_z = cmp_diff == 8'h00;

    // Compare updates five flags and the sign bit; I and T stay put.
    always_comb begin
        cmp_status_register = status_register_reg;
        cmp_status_register[CSBU_FLAG_H] = cmp_h; // see RULE1
        cmp_status_register[CSBU_FLAG_C] = cmp_c;
        cmp_status_register[CSBU_FLAG_V] = cmp_v;
        cmp_status_register[CSBU_FLAG_N] = cmp_n;
        cmp_status_register[CSBU_FLAG_Z] = cmp_z;
        cmp_status_register[CSBU_FLAG_S] = cmp_n ^ cmp_v;
    end

    // Software writes use byte lanes; skips and branches keep the flags.
    wire [31:0] pc_merged = csbu_merge({16'h0000, pc_reg}, wdata_reg,
        wstrb_reg);
    wire [31:0] status_register_merged = csbu_merge({24'h000000, status_register_reg}, wdata_reg,
        wstrb_reg);
    wire [31:0] opnd_merged = csbu_merge({8'h00, opnd_reg}, wdata_reg,
        wstrb_reg);
    assign pc_next = exec_fire ? pc_target :
        (hit_pc ? pc_merged[15:0] : pc_reg);
    assign status_register_next = (exec_fire && is_cmp) ? cmp_status_register :
        (hit_status_register ? status_register_merged[7:0] : status_register_reg); // see RULE13
    assign opnd_next = hit_opnd ? opnd_merged[23:0] : opnd_reg;

    // The unit stays busy for the clocks the instruction costs.
    assign busy_cnt_next = exec_fire ? cyc_count - CSBU_CYC_ONE :
        (busy ? busy_cnt_reg - CSBU_CYC_ONE : busy_cnt_reg); // see RULE14
    assign res_cyc_next = exec_fire ? cyc_count : res_cyc_reg;
    assign res_taken_next = exec_fire ? (take && !is_cmp) : res_taken_reg;
    assign bad_next = hit_ctrl ? !op_ok : bad_reg;

    // Execution state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_reg <= CSBU_PC_RST;
            status_register_reg <= CSBU_STATUS_REGISTER_RST;
            opnd_reg <= 24'h000000;
            busy_cnt_reg <= 2'h0;
            res_cyc_reg <= 2'h0;
            res_taken_reg <= 1'b0;
            bad_reg <= 1'b0;
        end else begin
            pc_reg <= pc_next;
            status_register_reg <= status_register_next;
            opnd_reg <= opnd_next;
            busy_cnt_reg <= busy_cnt_next;
            res_cyc_reg <= res_cyc_next;
            res_taken_reg <= res_taken_next;
            bad_reg <= bad_next;
        end
    end

    // A refused command still gets an answer, so the master never hangs.
    wire [1:0] wr_resp = (!hit_any || ctrl_err) ? CSBU_RESP_SLVERR :
        CSBU_RESP_OKAY;

    // Write channels: address and data are taken in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= CSBU_RESP_OKAY;
            awaddr_reg <= 5'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_reg) begin
                awready_reg <= 1'b0;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_reg) begin
                wready_reg <= 1'b0;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_resp;
            end
            if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // Read selection; reserved bits and unmapped words read as zero.
    wire [31:0] res_word = {22'h0, bad_reg, busy, 3'h0, res_taken_reg,
        2'h0, res_cyc_reg};
    wire rd_map = (s_axi_araddr == CSBU_OPND_OFF) ||
        (s_axi_araddr == CSBU_PC_OFF) || (s_axi_araddr == CSBU_STATUS_REGISTER_OFF) ||
        (s_axi_araddr == CSBU_RESULT_OFF) || (s_axi_araddr == CSBU_CTRL_OFF);
    wire [31:0] rd_word =
        (s_axi_araddr == CSBU_OPND_OFF) ? {8'h00, opnd_reg} :
        (s_axi_araddr == CSBU_PC_OFF) ? {16'h0000, pc_reg} :
        (s_axi_araddr == CSBU_STATUS_REGISTER_OFF) ? {24'h000000, status_register_reg} :
        (s_axi_araddr == CSBU_RESULT_OFF) ? res_word : 32'h00000000;

    // Read channels: one read in flight, answered the clock after the address.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= CSBU_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && arready_reg) begin
                arready_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_word;
                rresp_reg <= rd_map ? CSBU_RESP_OKAY : CSBU_RESP_SLVERR;
            end
            if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    default clocking csbu_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Busy window of a two- and a three-clock instruction.
    sequence csbu_two_clk;
        busy ##1 !busy;
    endsequence
    sequence csbu_three_clk;
        busy [*2] ##1 !busy;
    endsequence

    a_cmp_next_word: assert property (exec_fire && is_cmp |=> // see RULE1
        pc_reg == $past(pc_reg) + CSBU_STEP_NEXT && !busy)
        else $error("Compare did not step to the next word.");
    a_cmp_zero_flag: assert property (exec_fire && is_cmp && // see RULE1
        rd_val == imm_val |=> status_register_reg[CSBU_FLAG_Z] && !status_register_reg[CSBU_FLAG_C])
        else $error("Equal compare did not set zero and clear carry.");
    a_reg_skip_clear: assert property (exec_fire && // see RULE2
        op == skip_reg_bit_clear_op && !rd_val[sel] && !two_word |=>
        pc_reg == $past(pc_reg) + CSBU_STEP_SKIP1)
        else $error("Register bit clear skip missed its target.");
    a_reg_skip_set: assert property (exec_fire && // see RULE3
        op == skip_reg_bit_set_op && rd_val[sel] && two_word |=>
        pc_reg == $past(pc_reg) + CSBU_STEP_SKIP2)
        else $error("Register bit set skip missed its target.");
    a_io_skip_clear: assert property (exec_fire && // see RULE4
        op == skip_io_bit_clear_op && io_val[sel] |=>
        pc_reg == $past(pc_reg) + CSBU_STEP_NEXT && !res_taken_reg)
        else $error("I/O bit clear skip fired on a set bit.");
    a_io_skip_flags: assert property (exec_fire && // see RULE5
        op == skip_io_bit_set_op |=> $stable(status_register_reg))
        else $error("I/O bit set skip changed a flag.");
    a_branch_target: assert property (exec_fire && // see RULE6
        op >= branch_status_bit_set_op && take |=>
        pc_reg == $past(pc_reg) + CSBU_STEP_NEXT + $past(k_sext))
        else $error("Taken branch went to the wrong word.");
    a_branch_clear_hold: assert property (exec_fire && // see RULE7
        op == branch_status_bit_clear_op && status_register_reg[sel] |=>
        pc_reg == $past(pc_reg) + CSBU_STEP_NEXT)
        else $error("Status bit clear branch taken on a set bit.");
    a_carry_taken: assert property (exec_fire && // see RULE8
        op == branch_same_or_higher_op && !status_register_reg[CSBU_FLAG_C] |=>
        res_taken_reg) else $error("Same or higher branch not taken.");
    a_signed_ge: assert property (exec_fire && // see RULE9
        op == branch_signed_ge_op |=> res_taken_reg ==
        !($past(status_register_reg[CSBU_FLAG_N]) ^ $past(status_register_reg[CSBU_FLAG_V])))
        else $error("Signed greater or equal decided wrongly.");
    a_branch_two_clk: assert property (exec_fire && // see RULE14
        op >= branch_status_bit_set_op && take |=> csbu_two_clk)
        else $error("Taken branch did not last two clocks.");
    a_skip_three_clk: assert property (exec_fire && is_skip && // see RULE14
        take && two_word |=> csbu_three_clk)
        else $error("Long skip did not last three clocks.");
    a_overflow_flags: assert property (exec_fire && // see RULE13
        op == branch_overflow_set_op |=> $stable(status_register_reg))
        else $error("Overflow branch changed a flag.");
endmodule
`default_nettype wire

// ===== bench/csbu_axi_master.sv
`timescale 1ns/10ps
`default_nettype none
module csbu_axi_master (
    input wire logic aclk,
    output logic [csbu_pkg::CSBU_ADDR_W-1:0] s_axi_awaddr,
    output logic [2:0] s_axi_awprot,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [csbu_pkg::CSBU_ADDR_W-1:0] s_axi_araddr,
    output logic [2:0] s_axi_arprot,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    import csbu_pkg::*;

    // The bus is quiet from time zero so nothing is requested during reset.
    initial begin
        s_axi_awaddr = '0;
        s_axi_awprot = 3'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arprot = 3'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
    end

    // Each valid drops only at the edge where its ready was seen high.
    task automatic write_word(input logic [4:0] a, input logic [31:0] d,
            output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Read data is taken at the same edge that completes the handshake.
    task automatic read_word(input logic [4:0] a, output logic [31:0] d,
            output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== bench/tb_compare_skip_branch_unit.sv
`timescale 1ns/10ps
`default_nettype none
module tb_compare_skip_branch_unit;
    import csbu_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [CSBU_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int error_cnt = 0;
    int checks = 0;

    csbu_top dut (.*);
    csbu_axi_master mst (.*);

    // Free-running 250 MHz clock.
    initial aclk = 1'b0;
    always #2 aclk = ~aclk;

    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d,
            input logic [1:0] er);
        logic [1:0] r;
        mst.write_word(a, d, r);
        check("bresp", 32'(r), 32'(er));
    endtask

    task automatic rd(input logic [4:0] a, input logic [1:0] er,
            output logic [31:0] d);
        logic [1:0] r;
        mst.read_word(a, d, r);
        check("rresp", 32'(r), 32'(er));
    endtask

    // Loads operands, status and pc, executes, then reads pc, status and result back.
    task automatic run_op(input logic [4:0] op, input logic [2:0] sel,
            input logic [6:0] k, input logic two, input logic [31:0] opnd,
            input logic [7:0] sr, input logic [15:0] epc,
            input logic [7:0] esr, input logic [1:0] cyc, input logic tk);
        logic [31:0] d;
        wr(CSBU_OPND_OFF, opnd, CSBU_RESP_OKAY);
        wr(CSBU_STATUS_REGISTER_OFF, {24'h0, sr}, CSBU_RESP_OKAY);
        wr(CSBU_PC_OFF, 32'h0000_0100, CSBU_RESP_OKAY);
        wr(CSBU_CTRL_OFF, {15'h0, two, 1'b0, k, sel, op}, CSBU_RESP_OKAY);
        rd(CSBU_PC_OFF, CSBU_RESP_OKAY, d);
        check("pc", d, {16'h0, epc});
        rd(CSBU_STATUS_REGISTER_OFF, CSBU_RESP_OKAY, d);
        check("status", d, {24'h0, esr});
        rd(CSBU_RESULT_OFF, CSBU_RESP_OKAY, d);
        check("result", d & 32'h313, {27'h0, tk, 2'h0, cyc});
    endtask

    // Flags from plain orderings, not the borrow chain; I and T stay.
    function automatic logic [7:0] cmp_flags(input logic [7:0] a,
            input logic [7:0] b, input logic [7:0] sr);
        logic [7:0] r;
        logic [7:0] f;
        r = a - b;
        f = sr & 8'hc0;
        f[CSBU_FLAG_C] = a < b;
        f[CSBU_FLAG_Z] = a == b;
        f[CSBU_FLAG_N] = r[7];
        f[CSBU_FLAG_V] = (a[7] != b[7]) && (r[7] != a[7]);
        f[CSBU_FLAG_S] = r[7] ^ f[CSBU_FLAG_V];
        f[CSBU_FLAG_H] = a[3:0] < b[3:0];
        return f;
    endfunction

    function automatic logic br_cond(input int op, input logic [7:0] sr,
            input logic [2:0] sel);
        case (op)
            5: return sr[sel];
            6: return ~sr[sel];
            7, 10: return sr[CSBU_FLAG_C];
            8, 9: return ~sr[CSBU_FLAG_C];
            11: return ~(sr[CSBU_FLAG_N] ^ sr[CSBU_FLAG_V]);
            12: return sr[CSBU_FLAG_N] ^ sr[CSBU_FLAG_V];
            13: return sr[CSBU_FLAG_H];
            14: return ~sr[CSBU_FLAG_H];
            15: return sr[CSBU_FLAG_T];
            16: return ~sr[CSBU_FLAG_T];
            default: return sr[CSBU_FLAG_V];
        endcase
    endfunction

    task automatic reset_values();
        logic [31:0] d;
        rd(CSBU_PC_OFF, CSBU_RESP_OKAY, d);
        check("pc reset", d, 32'h0);
        rd(CSBU_STATUS_REGISTER_OFF, CSBU_RESP_OKAY, d);
        check("status reset", d, 32'h0);
        rd(CSBU_RESULT_OFF, CSBU_RESP_OKAY, d);
        check("result reset", d, 32'h0);
    endtask

    // Equal, borrow, signed overflow and plain cases, with I and T both ways.
    task automatic compare_op();
        logic [7:0] a [4] = '{8'h10, 8'h00, 8'h80, 8'h05};
        logic [7:0] b [4] = '{8'h10, 8'h01, 8'h01, 8'h03};
        logic [7:0] sr;
        for (int i = 0; i < 4; i++) begin
            sr = i[0] ? 8'hc0 : 8'h3f;
            run_op(5'h00, 3'h0, 7'h00, 1'b0, {16'h0, b[i], a[i]}, sr,
                16'h0101, cmp_flags(a[i], b[i], sr), CSBU_CYC_ONE,
                1'b0);
        end
    endtask

    // The I/O byte is the inverse of the register so a wrong source shows.
    task automatic skip_ops();
        logic [2:0] s;
        logic sk;
        for (int op = 1; op <= 4; op++) begin
            for (int i = 0; i < 4; i++) begin
                s = 3'(op + i);
                sk = 1'((op < 3 ? 8'h5a : 8'ha5) >> s);
                sk = op[0] ? ~sk : sk;
                run_op(5'(op), s, 7'h00, i[1], 32'h00a5_005a, 8'h55,
                    16'h0100 + (sk ? (i[1] ? 16'h3 : 16'h2) : 16'h1), 8'h55,
                    sk ? (i[1] ? CSBU_CYC_THREE : CSBU_CYC_TWO) : CSBU_CYC_ONE,
                    sk);
            end
        end
    endtask

    // Four status patterns give every branch both outcomes, k both signs.
    task automatic branch_ops();
        logic [7:0] srs [4] = '{8'h00, 8'hff, 8'h55, 8'haa};
        logic [6:0] k;
        logic [2:0] s;
        logic t;
        logic [15:0] epc;
        for (int op = 5; op <= 17; op++) begin
            for (int i = 0; i < 4; i++) begin
                s = 3'(op + i);
                k = i[0] ? 7'h7e : 7'h05;
                t = br_cond(op, srs[i], s);
                epc = 16'h0101 + (t ? {{9{k[6]}}, k} : 16'h0);
                run_op(5'(op), s, k, 1'b0, 32'h0, srs[i], epc, srs[i],
                    t ? CSBU_CYC_TWO : CSBU_CYC_ONE,
                    t);
            end
        end
    endtask

    task automatic refuse_ops();
        logic [31:0] d;
        wr(CSBU_PC_OFF, 32'h0000_0100, CSBU_RESP_OKAY);
        wr(CSBU_CTRL_OFF, 32'h0000_0012, CSBU_RESP_SLVERR);
        rd(CSBU_RESULT_OFF, CSBU_RESP_OKAY, d);
        check("bad op flag", d & 32'h200, 32'h200);
        rd(CSBU_PC_OFF, CSBU_RESP_OKAY, d);
        check("pc kept", d, 32'h100);
        rd(5'h14, CSBU_RESP_SLVERR, d);
        check("unmapped data", d, 32'h0);
        wr(5'h14, 32'hffff_ffff, CSBU_RESP_SLVERR);
    endtask

    task automatic tally_and_finish();
        $display("errors %0d, checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Main sequence after a 16-cycle reset.
    initial begin
        aresetn = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        reset_values();
        compare_op();
        skip_ops();
        branch_ops();
        refuse_ops();
        tally_and_finish();
    end

    // Roughly ten times the expected run, so a hung handshake ends it.
    initial begin
        #80000;
        error_cnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
